// ===== verilog/cpad_aligner.sv
`timescale 1ns/10ps
`include "cpad_regs.svh"
module cpad_aligner
    import cpad_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [4:0] measured_phase,
    output logic [8:0] delay_tap_setting,
    output logic [7:0] phase_det_ctrl,
    output logic dcc_enable
);
    logic [7:0] r24_r, r25_r, r26_r, r27_r, r28_r, r29_r, rd_r;
    logic [7:0] r24_nxt, r25_nxt, r26_nxt, r27_nxt, r28_nxt, r29_nxt;
    logic [7:0] rd_nxt;
    cpad_state_t st_r, st_nxt;
    logic [8:0] dly_r, dly_nxt, base_r, base_nxt;
    logic [8:0] up_off_r, up_off_nxt, dn_off_r, dn_off_nxt;
    logic [4:0] base_ph_r, base_ph_nxt;
    logic side_r, side_nxt, beyond_r, beyond_nxt, probe_dn_r, probe_dn_nxt;
    logic locked_r, locked_nxt, lost_r, lost_nxt, failed_r, failed_nxt;
    logic wr26, start, stop, tick, run, want_neg, match, restart_loss;
    logic up_ok, dn_ok, oor, far, near, go_up, slope_neg, keepout;
    logic [4:0] target;
    logic signed [4:0] err, pdiff;
    logic [4:0] err_abs;
    logic [1:0] gain;
    logic signed [10:0] start_s, lo, hi, up_c, dn_c, req, stepv, guard8;

    assign wr26 = reg_wr && reg_addr == `CPAD_OFS_EN_GAIN;
    assign start = wr26 && reg_wdata[`CPAD_EN_BIT];
    assign stop = wr26 && !reg_wdata[`CPAD_EN_BIT];
    assign target = r27_r[4:0];
    assign want_neg = !r25_r[`CPAD_SLOPE_POS_BIT];
    assign restart_loss = r29_r[`CPAD_RST_LOSS_BIT];
    assign start_s = {2'b00, r28_r, r27_r[`CPAD_TAP0_BIT]};
    assign guard8 = 11'({r29_r[4:0], 3'b000});
    assign lo = beyond_r ? 11'sh000 : guard8;
    assign hi = beyond_r ? `CPAD_TAP_MAX : `CPAD_TAP_MAX - guard8;
    assign up_c = start_s + 11'({2'b00, up_off_r}) + 11'sh001;
    assign dn_c = start_s - 11'({2'b00, dn_off_r}) - 11'sh001;
    assign up_ok = up_c <= hi;
    assign dn_ok = dn_c >= lo;
    assign err = measured_phase - target; // Wraps mod 32
    assign err_abs = err[4] ? 5'(-err) : err;
    assign pdiff = measured_phase - base_ph_r;
    assign match = r29_r[`CPAD_EXACT_BIT] ? err == 5'sh00
                                          : err_abs <= 5'h01;
    assign far = err_abs > `CPAD_LOCK_OUT;
    assign near = err_abs <= `CPAD_LOCK_IN;
    assign keepout = measured_phase <= `CPAD_KEEPOUT;
    assign gain = r26_r[2:1] == 2'b00 ? 2'b01 : r26_r[2:1];
    assign stepv = 11'({9'h000, gain});
    assign go_up = want_neg ? !err[4] : err[4];
    assign req = go_up ? 11'({2'b00, dly_r}) + stepv
                       : 11'({2'b00, dly_r}) - stepv;
    assign oor = req < 11'sh000 || req > `CPAD_TAP_MAX;
    assign slope_neg = probe_dn_r ? pdiff > 5'sh00 : pdiff < 5'sh00;
    assign run = st_r == CPAD_SEARCH || st_r == CPAD_SLOPE
                 || st_r == CPAD_TRACK;

    cpad_settle_timer u_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .run(run),
        .restart(wr26),
        .tick(tick)
    );

    // Configuration registers and readback
    always_comb
    begin
        r24_nxt = r24_r;
        r25_nxt = r25_r;
        r26_nxt = r26_r;
        r27_nxt = r27_r;
        r28_nxt = r28_r;
        r29_nxt = r29_r;
        if (reg_wr)
        begin
            case (reg_addr)
                `CPAD_OFS_PD_CTRL: r24_nxt = reg_wdata;
                `CPAD_OFS_SLOPE_DCC: r25_nxt = reg_wdata;
                `CPAD_OFS_EN_GAIN: r26_nxt = reg_wdata;
                `CPAD_OFS_PHASE_HI: r27_nxt = reg_wdata;
                `CPAD_OFS_TAP_LO: r28_nxt = reg_wdata;
                `CPAD_OFS_GUARD: r29_nxt = reg_wdata;
                default: r24_nxt = r24_r;
            endcase
        end
        case (reg_addr)
            `CPAD_OFS_PD_CTRL: rd_nxt = r24_r;
            `CPAD_OFS_SLOPE_DCC: rd_nxt = r25_r;
            `CPAD_OFS_EN_GAIN: rd_nxt = r26_r;
            `CPAD_OFS_PHASE_HI: rd_nxt = r26_r[`CPAD_RD_BIT]
                ? {dly_r[0], r27_r[6:0]} : r27_r;
            `CPAD_OFS_TAP_LO: rd_nxt = r26_r[`CPAD_RD_BIT]
                ? dly_r[8:1] : r28_r;
            `CPAD_OFS_GUARD: rd_nxt = r29_r;
            `CPAD_OFS_STATUS: rd_nxt = {3'b000, keepout, failed_r,
                st_r == CPAD_TRACK, lost_r, locked_r};
            default: rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r24_r <= `CPAD_RST_VAL;
            r25_r <= `CPAD_RST_VAL;
            r26_r <= `CPAD_RST_VAL;
            r27_r <= `CPAD_RST_VAL;
            r28_r <= `CPAD_RST_VAL;
            r29_r <= `CPAD_RST_VAL;
            rd_r <= 8'h00;
        end
        else
        begin
            r24_r <= r24_nxt;
            r25_r <= r25_nxt;
            r26_r <= r26_nxt;
            r27_r <= r27_nxt;
            r28_r <= r28_nxt;
            r29_r <= r29_nxt;
            rd_r <= rd_nxt;
        end
    end

    // Search and track controller
    always_comb
    begin
        st_nxt = st_r;
        dly_nxt = dly_r;
        base_nxt = base_r;
        base_ph_nxt = base_ph_r;
        up_off_nxt = up_off_r;
        dn_off_nxt = dn_off_r;
        side_nxt = side_r;
        beyond_nxt = beyond_r;
        probe_dn_nxt = probe_dn_r;
        locked_nxt = locked_r;
        lost_nxt = lost_r;
        failed_nxt = failed_r;
        if (stop)
        begin
            st_nxt = CPAD_IDLE;
            locked_nxt = 1'b0;
        end
        else if (start)
        begin
            st_nxt = CPAD_SEARCH;
            dly_nxt = start_s[8:0];
            up_off_nxt = 9'h000;
            dn_off_nxt = 9'h000;
            side_nxt = 1'b0;
            beyond_nxt = 1'b0;
            locked_nxt = 1'b0;
            lost_nxt = 1'b0;
            failed_nxt = 1'b0;
        end
        else if (tick)
        begin
            case (st_r)
                CPAD_SEARCH:
                begin
                    if (match)
                    begin
                        st_nxt = CPAD_SLOPE;
                        base_nxt = dly_r;
                        base_ph_nxt = measured_phase;
                        probe_dn_nxt = dly_r == 9'(`CPAD_TAP_MAX);
                        dly_nxt = dly_r == 9'(`CPAD_TAP_MAX)
                                  ? dly_r - 9'h001 : dly_r + 9'h001;
                    end
                    else if (up_ok && (!side_r || !dn_ok))
                    begin
                        dly_nxt = up_c[8:0];
                        up_off_nxt = up_off_r + 9'h001;
                        side_nxt = 1'b1;
                    end
                    else if (dn_ok)
                    begin
                        dly_nxt = dn_c[8:0];
                        dn_off_nxt = dn_off_r + 9'h001;
                        side_nxt = 1'b0;
                    end
                    else if (!beyond_r)
                    begin
                        beyond_nxt = 1'b1;
                    end
                    else
                    begin
                        failed_nxt = 1'b1;
                        dly_nxt = start_s[8:0];
                        up_off_nxt = 9'h000;
                        dn_off_nxt = 9'h000;
                        beyond_nxt = 1'b0;
                        st_nxt = r29_r[`CPAD_RETRY_BIT] ? CPAD_SEARCH
                                                        : CPAD_FAIL;
                    end
                end
                CPAD_SLOPE:
                begin
                    if (slope_neg == want_neg)
                    begin
                        dly_nxt = base_r;
                        st_nxt = CPAD_TRACK;
                        locked_nxt = 1'b1;
                        lost_nxt = 1'b0;
                    end
                    else
                    begin
                        st_nxt = CPAD_SEARCH;
                    end
                end
                CPAD_TRACK:
                begin
                    if (err != 5'sh00 && !oor)
                    begin
                        dly_nxt = req[8:0];
                    end
                    if (far || (oor && err != 5'sh00))
                    begin
                        locked_nxt = 1'b0;
                        lost_nxt = lost_r || locked_r;
                        if (restart_loss)
                        begin
                            st_nxt = CPAD_SEARCH;
                            dly_nxt = start_s[8:0];
                            up_off_nxt = 9'h000;
                            dn_off_nxt = 9'h000;
                            side_nxt = 1'b0;
                            beyond_nxt = 1'b0;
                        end
                    end
                    else if (near)
                    begin
                        locked_nxt = 1'b1;
                        lost_nxt = 1'b0;
                    end
                end
                CPAD_IDLE, CPAD_FAIL: st_nxt = st_r;
                default: st_nxt = CPAD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= CPAD_IDLE;
            dly_r <= 9'h000;
            base_r <= 9'h000;
            base_ph_r <= 5'h00;
            up_off_r <= 9'h000;
            dn_off_r <= 9'h000;
            side_r <= 1'b0;
            beyond_r <= 1'b0;
            probe_dn_r <= 1'b0;
            locked_r <= 1'b0;
            lost_r <= 1'b0;
            failed_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            dly_r <= dly_nxt;
            base_r <= base_nxt;
            base_ph_r <= base_ph_nxt;
            up_off_r <= up_off_nxt;
            dn_off_r <= dn_off_nxt;
            side_r <= side_nxt;
            beyond_r <= beyond_nxt;
            probe_dn_r <= probe_dn_nxt;
            locked_r <= locked_nxt;
            lost_r <= lost_nxt;
            failed_r <= failed_nxt;
        end
    end

    assign delay_tap_setting = dly_r;
    assign reg_rdata = rd_r;
    assign phase_det_ctrl = r24_r;
    assign dcc_enable = r25_r[`CPAD_DCC_BIT];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_tap_range: assert property (dly_r <= 9'(`CPAD_TAP_MAX))
        else $error("tap above range");
    a_start_tap: assert property (start |=> st_r == CPAD_SEARCH
        && dly_r == $past(start_s[8:0])) else $error("bad search start");
    a_lock_drop: assert property (st_r == CPAD_TRACK && tick && far
        && !wr26 |=> !locked_r && lost_r == $past(lost_r || locked_r))
        else $error("lock not dropped");
    a_lock_back: assert property (st_r == CPAD_TRACK && tick && near
        && !oor && !wr26 |=> locked_r && !lost_r)
        else $error("lock not regained");
    a_track_step: assert property (st_r == CPAD_TRACK && tick
        && err != 5'sh00 && !oor && !wr26 |=> dly_r != $past(dly_r))
        else $error("tracking did not step");
    a_loss_restart: assert property (st_r == CPAD_TRACK && tick && far
        && restart_loss && !wr26 |=> st_r == CPAD_SEARCH)
        else $error("no restart on loss");
    a_guard_keep: assert property (st_r == CPAD_SEARCH && tick
        && !match && !wr26 && (up_ok || dn_ok) |=>
        $signed({2'b00, dly_r}) >= $past(lo)
        && $signed({2'b00, dly_r}) <= $past(hi))
        else $error("step crossed guard");
    a_fail_stop: assert property (st_r == CPAD_SEARCH && tick && !match
        && !up_ok && !dn_ok && beyond_r && !wr26 |=> failed_r
        && st_r == (r29_r[`CPAD_RETRY_BIT] ? CPAD_SEARCH : CPAD_FAIL))
        else $error("endpoint not handled");
    c_track: cover property (st_r == CPAD_SLOPE ##1 st_r == CPAD_TRACK);
    c_beyond: cover property (!beyond_r ##1 beyond_r);
    c_fail: cover property (st_r == CPAD_FAIL);
endmodule : cpad_aligner

// ===== verilog/cpad_regs.svh
`ifndef CPAD_REGS_SVH
`define CPAD_REGS_SVH
// Register offsets
`define CPAD_OFS_PD_CTRL 8'h24
`define CPAD_OFS_SLOPE_DCC 8'h25
`define CPAD_OFS_EN_GAIN 8'h26
`define CPAD_OFS_PHASE_HI 8'h27
`define CPAD_OFS_TAP_LO 8'h28
`define CPAD_OFS_GUARD 8'h29
`define CPAD_OFS_STATUS 8'h2a
`define CPAD_RST_VAL 8'h00
// Field positions
`define CPAD_DCC_BIT 7
`define CPAD_SLOPE_POS_BIT 6
`define CPAD_EN_BIT 0
`define CPAD_RD_BIT 3
`define CPAD_MODE_BIT 6
`define CPAD_TAP0_BIT 7
`define CPAD_EXACT_BIT 7
`define CPAD_RETRY_BIT 6
`define CPAD_RST_LOSS_BIT 5
// Delay line and phase scale
`define CPAD_LINE_PS 864
`define CPAD_TAP_PS 2
`define CPAD_TAP_MAX 11'sh1b0
`define CPAD_GUARD_SHIFT 3
`define CPAD_PH_HALF 5'h10
`define CPAD_KEEPOUT 5'h02
`define CPAD_LOCK_OUT 5'h04
`define CPAD_LOCK_IN 5'h03
// Timing
`define CPAD_CLK_NS 50
`define CPAD_SETTLE_NS 500
`define CPAD_SETTLE_CYC \
    ((`CPAD_SETTLE_NS + `CPAD_CLK_NS - 1) / `CPAD_CLK_NS)
`endif

// ===== verilog/cpad_pkg.sv
package cpad_pkg;
    typedef enum logic [2:0] {
        CPAD_IDLE = 3'b000,
        CPAD_SEARCH = 3'b001,
        CPAD_SLOPE = 3'b011,
        CPAD_TRACK = 3'b010,
        CPAD_FAIL = 3'b110
    } cpad_state_t;
endpackage : cpad_pkg

// ===== verilog/cpad_settle_timer.sv
`timescale 1ns/10ps
`include "cpad_regs.svh"
module cpad_settle_timer
    import cpad_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic restart,
    output logic tick
);
    localparam logic [7:0] LAST = 8'(`CPAD_SETTLE_CYC - 1);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    // Measurement settles after each tap change
    always_comb
    begin
        cnt_nxt = cnt_r + 8'h01;
        if (restart || !run || cnt_r == LAST)
        begin
            cnt_nxt = 8'h00;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_r <= 8'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick = run && !restart && cnt_r == LAST;
endmodule : cpad_settle_timer

// ===== dv/cpad_phase_model.sv
`timescale 1ns/10ps
module cpad_phase_model
    import cpad_pkg::*;
#(
    parameter int PH_BASE = 225
)
(
    input wire logic [8:0] tap,
    input wire logic [4:0] drift,
    output logic [4:0] measured_phase
);
    logic [9:0] ph_sum;

    // Phase falls one step per tap, wraps every 32 taps
    always_comb
    begin
        ph_sum = 10'(PH_BASE) + {5'h0_0, drift} - {1'b0, tap};
        measured_phase = ph_sum[4:0];
    end
endmodule : cpad_phase_model

// ===== dv/test_clock_phase_align_dll.sv
`timescale 1ns/10ps
`include "cpad_regs.svh"
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module test_clock_phase_align_dll
    import cpad_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [4:0] measured_phase;
    logic [8:0] delay_tap_setting;
    logic [7:0] phase_det_ctrl;
    logic dcc_enable;
    logic [4:0] drift = 5'h00;
    logic [7:0] rd;
    logic [8:0] tap_hold;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;

    cpad_aligner u_dut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .measured_phase(measured_phase),
        .delay_tap_setting(delay_tap_setting),
        .phase_det_ctrl(phase_det_ctrl),
        .dcc_enable(dcc_enable)
    );

    cpad_phase_model #(.PH_BASE(225)) u_ph (
        .tap(delay_tap_setting),
        .drift(drift),
        .measured_phase(measured_phase)
    );

    always #25 core_clk = ~core_clk;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        @(negedge core_clk);
        reg_addr = a;
        @(negedge core_clk);
        rd = reg_rdata;
    endtask : rd_reg

    task automatic wait_stat(input logic [7:0] m, input logic [7:0] v,
                             input int lim);
        int i;
        i = 0;
        rd_reg(`CPAD_OFS_STATUS);
        while ((rd & m) !== v && i < lim)
        begin
            rd_reg(`CPAD_OFS_STATUS);
            i++;
        end
        `CHK(rd & m, v)
    endtask : wait_stat

    task automatic wait_tap(input logic [8:0] v, input int lim);
        int i;
        i = 0;
        while (delay_tap_setting !== v && i < lim)
        begin
            @(negedge core_clk);
            i++;
        end
        `CHK(delay_tap_setting, v)
    endtask : wait_tap

    task automatic end_test(input string name);
        $display("test %s done, errors %0d", name, error_cnt);
    endtask : end_test

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    always @(posedge core_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 60000)
        begin
            error_cnt++;
            results();
        end
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        // Reset values and unmapped read
        for (int a = 8'h24; a <= 8'h2a; a++)
        begin
            rd_reg(8'(a));
            `CHK(rd, (a == 8'h2a) ? 8'h10 : 8'h00)
        end
        rd_reg(8'h30);
        `CHK(rd, 8'h00)
        `CHK(delay_tap_setting, 9'h000)
        end_test("reset");
        // Boot sequence and readback
        wr(`CPAD_OFS_PD_CTRL, 8'h30);
        wr(`CPAD_OFS_SLOPE_DCC, 8'h80);
        wr(`CPAD_OFS_PHASE_HI, 8'h46);
        wr(`CPAD_OFS_TAP_LO, 8'h6c);
        wr(`CPAD_OFS_GUARD, 8'hcb);
        wr(`CPAD_OFS_STATUS, 8'hff);
        rd_reg(`CPAD_OFS_STATUS);
        `CHK(rd, 8'h10)
        rd_reg(`CPAD_OFS_GUARD);
        `CHK(rd, 8'hcb)
        rd_reg(`CPAD_OFS_TAP_LO);
        `CHK(rd, 8'h6c)
        `CHK(phase_det_ctrl, 8'h30)
        `CHK(dcc_enable, 1'b1)
        wr(`CPAD_OFS_EN_GAIN, 8'h03);
        wait_tap(9'd216, 3);
        end_test("boot");
        // Alternating search finds tap 219, negative slope
        wait_stat(8'h01, 8'h01, 2000);
        `CHK(delay_tap_setting, 9'd219)
        rd_reg(`CPAD_OFS_STATUS);
        `CHK(rd, 8'h05)
        rd_reg(`CPAD_OFS_TAP_LO);
        `CHK(rd, 8'h6c)
        end_test("lock");
        // Small drift tracked without losing lock
        drift = 5'd2;
        wait_tap(9'd221, 200);
        rd_reg(`CPAD_OFS_STATUS);
        `CHK(rd, 8'h05)
        `CHK(measured_phase, 5'd6)
        end_test("track");
        // Jump beyond four steps: lost, then relock while tracking
        drift = 5'd8;
        wait_stat(8'h03, 8'h02, 50);
        wait_stat(8'h03, 8'h01, 400);
        wait_tap(9'd227, 200);
        end_test("loss");
        // Restart with read bit, in-use tap shown
        wr(`CPAD_OFS_EN_GAIN, 8'h0b);
        wait_tap(9'd216, 3);
        wait_stat(8'h01, 8'h01, 2000);
        `CHK(delay_tap_setting, 9'd227)
        rd_reg(`CPAD_OFS_TAP_LO);
        `CHK(rd, 8'h71)
        rd_reg(`CPAD_OFS_PHASE_HI);
        `CHK(rd, 8'hc6)
        end_test("readbit");
        // Restart on loss selected
        wr(`CPAD_OFS_GUARD, 8'heb);
        drift = 5'd16;
        wait_tap(9'd216, 100);
        wait_stat(8'h01, 8'h01, 2000);
        `CHK(delay_tap_setting, 9'd203)
        end_test("restart");
        // Positive slope never matches: search fails and stops
        wr(`CPAD_OFS_GUARD, 8'h8b);
        wr(`CPAD_OFS_SLOPE_DCC, 8'hc0);
        wr(`CPAD_OFS_EN_GAIN, 8'h03);
        wait_stat(8'h08, 8'h08, 20000);
        `CHK(rd[0], 1'b0)
        tap_hold = delay_tap_setting;
        repeat (40) @(negedge core_clk);
        `CHK(delay_tap_setting, tap_hold)
        end_test("fail");
        results();
    end
endmodule : test_clock_phase_align_dll
